// [verilog/b3c_top.sv]
// Purpose: buck3 control and configuration register slice on Avalon-MM
// Assumes: 32-bit Avalon-MM slave, byte address, one wait state per access
// Notes: registers sit in the low 16 bits of each word
//
// Notes on behaviour
// - The soft-start field picks immediate start or 512us, 4.096ms or 32.768ms per each of three steps, reset 01.
// - The hysteretic current-limit field picks 50, 100, 200 or 400 mA, reset 01.
// - The current-limit field takes writes only while the user key is unlocked.
// - The capacitor field changes only by a configuration load and is read-only to software.
// - The ON voltage select upper bits sit at 6:2 of the ON register and reset to zero.
// - The seven-bit ON code gives 0.85V to 3.375V in 25mV steps, codes 66h to 7Fh all at maximum.
`include "b3c_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module b3c_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [`B3C_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // configuration load
  input wire logic cfg_load,
  input wire logic [1:0] cfg_capacitor,
  input wire logic [4:0] cfg_voltage_hi,
  // converter control
  input wire logic ss_start,
  output logic [1:0] soft_start_step_time,
  output logic [1:0] hysteretic_current_limit,
  output logic [1:0] output_capacitor_range,
  output logic overvoltage_protect_enable,
  output logic [6:0] on_state_voltage_code,
  output logic [11:0] on_voltage_mv,
  output logic [1:0] ss_limit_stage,
  output logic ss_done
);
  b3c_pkg::b3c_regs_s r_reg;
  b3c_pkg::b3c_regs_s r_next;
  logic [15:0] wmask;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [6:0] code_next;
  logic [1:0] ss_stage_w;
  logic ss_done_w;
  logic ss_start_q;

  // ----------------------------------------------------------------
  // soft-start sequencer
  // ----------------------------------------------------------------
  b3c_sstart u_sstart (
    .clk(clk),
    .rst_n(rst_n),
    .start(ss_start_q),
    .step_code(r_reg.ctrl1[`B3C_SS_LSB +: 2]),
    .limit_stage(ss_stage_w),
    .done(ss_done_w)
  );

  // ----------------------------------------------------------------
  // register update
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wdata = avs_writedata[15:0];
    rdata = 16'h0000;
    code_next = 7'h00;
    r_next.waitrequest = 1'b1;
    r_next.resp_pending = 1'b0;
    if ((avs_read || avs_write) && !r_reg.resp_pending) begin
      r_next.resp_pending = 1'b1;
      r_next.waitrequest = 1'b0;
      if (avs_write) begin
        case (avs_address)
          `B3C_ADDR_CTRL1: begin
            // soft start, phase, filter writable; cap kept
            r_next.ctrl1 = (r_reg.ctrl1 & ~(wmask & `B3C_CTRL1_SW_MASK)) |
              (wdata & wmask & `B3C_CTRL1_SW_MASK);
            if (r_reg.unlocked) begin
              r_next.ctrl1[`B3C_LIM_LSB +: 2] = wmask[`B3C_LIM_LSB] ?
                wdata[`B3C_LIM_LSB +: 2] : r_reg.ctrl1[`B3C_LIM_LSB +: 2];
            end
          end
          `B3C_ADDR_CTRL2: begin
            r_next.ctrl2 = (r_reg.ctrl2 & ~(wmask & `B3C_CTRL2_MASK)) |
              (wdata & wmask & `B3C_CTRL2_MASK);
          end
          `B3C_ADDR_ONCFG: begin
            r_next.oncfg = (r_reg.oncfg & ~(wmask & `B3C_ONCFG_MASK)) |
              (wdata & wmask & `B3C_ONCFG_MASK);
          end
          `B3C_ADDR_B2SC: begin
            r_next.b2sc = (r_reg.b2sc & ~(wmask & `B3C_B2SC_MASK)) |
              (wdata & wmask & `B3C_B2SC_MASK);
          end
          `B3C_ADDR_KEY: begin
            if (wmask == 16'hFFFF) begin
              r_next.unlocked = (wdata == `B3C_KEY_VALUE);
            end
          end
          default: begin
          end
        endcase
      end else begin
        case (avs_address)
          `B3C_ADDR_CTRL1: rdata = r_reg.ctrl1 & `B3C_CTRL1_MASK;
          `B3C_ADDR_CTRL2: rdata = r_reg.ctrl2 & `B3C_CTRL2_MASK;
          `B3C_ADDR_ONCFG: rdata = r_reg.oncfg & `B3C_ONCFG_MASK;
          `B3C_ADDR_B2SC: rdata = r_reg.b2sc & `B3C_B2SC_MASK;
          `B3C_ADDR_KEY: rdata = {15'h0000, r_reg.unlocked};
          default: rdata = 16'h0000;
        endcase
        r_next.readdata = {16'h0000, rdata};
      end
    end
    // configuration load wins over software
    if (cfg_load) begin
      r_next.ctrl1[`B3C_CAP_LSB +: 2] = cfg_capacitor;
      r_next.oncfg[`B3C_VHI_LSB +: 5] = cfg_voltage_hi;
    end
    // voltage code clamp
    code_next = r_next.oncfg[6:0];
    if (code_next > `B3C_VCODE_MAX) begin
      code_next = `B3C_VCODE_MAX;
    end
    r_next.vcode = code_next;
    r_next.vout_mv = 12'(`B3C_VMIN_MV + 32'(code_next) * `B3C_VSTEP_MV);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r_reg <= '0;
      r_reg.ctrl1 <= `B3C_CTRL1_RST;
      r_reg.ctrl2 <= `B3C_CTRL2_RST;
      r_reg.oncfg <= `B3C_ONCFG_RST;
      r_reg.b2sc <= `B3C_B2SC_RST;
      r_reg.waitrequest <= 1'b1;
      r_reg.vout_mv <= 12'(`B3C_VMIN_MV);
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ss_start_q <= 1'b0;
      soft_start_step_time <= 2'h1;
      hysteretic_current_limit <= 2'h1;
      output_capacitor_range <= 2'h0;
      overvoltage_protect_enable <= 1'b0;
      on_state_voltage_code <= 7'h00;
      on_voltage_mv <= 12'(`B3C_VMIN_MV);
      ss_limit_stage <= 2'h0;
      ss_done <= 1'b0;
    end else begin
      ss_start_q <= ss_start;
      soft_start_step_time <= r_reg.ctrl1[`B3C_SS_LSB +: 2];
      hysteretic_current_limit <= r_reg.ctrl1[`B3C_LIM_LSB +: 2];
      output_capacitor_range <= r_reg.ctrl1[`B3C_CAP_LSB +: 2];
      overvoltage_protect_enable <= r_reg.ctrl2[`B3C_OVP_BIT];
      on_state_voltage_code <= r_reg.vcode;
      on_voltage_mv <= r_reg.vout_mv;
      ss_limit_stage <= ss_stage_w;
      ss_done <= ss_done_w;
    end
  end

  assign avs_readdata = r_reg.readdata;
  assign avs_waitrequest = r_reg.waitrequest;
endmodule
`default_nettype wire

// [verilog/b3c_defines.svh]
// Purpose: offsets, field positions, reset values and timing counts for the buck3 register slice
// Assumes: 50 MHz clock, Avalon-MM byte addressing, four bytes per register index
// Notes: byte address is four times the register index
`ifndef B3C_DEFINES_SVH
`define B3C_DEFINES_SVH

// ----------------------------------------------------------------
// register indices and byte addresses
// ----------------------------------------------------------------
`define B3C_IDX_CTRL1 16'h4060
`define B3C_IDX_CTRL2 16'h4061
`define B3C_IDX_ONCFG 16'h4062
`define B3C_IDX_B2SC 16'h405F
`define B3C_ADDR_W 18
`define B3C_ADDR_CTRL1 18'h10180
`define B3C_ADDR_CTRL2 18'h10184
`define B3C_ADDR_ONCFG 18'h10188
`define B3C_ADDR_B2SC 18'h1017C
`define B3C_ADDR_KEY 18'h10200

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define B3C_SS_LSB 4
`define B3C_LIM_LSB 2
`define B3C_CAP_LSB 0
`define B3C_OVP_BIT 7
`define B3C_VHI_LSB 2
`define B3C_VLO_LSB 0
`define B3C_B2V_LSB 0
`define B3C_CTRL1_MASK 16'h10BF
`define B3C_CTRL1_SW_MASK 16'h10B0
`define B3C_CTRL2_MASK 16'hDF80
`define B3C_ONCFG_MASK 16'hE37F
`define B3C_B2SC_MASK 16'h187F

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define B3C_CTRL1_RST 16'h0014
`define B3C_CTRL2_RST 16'h0300
`define B3C_ONCFG_RST 16'h0000
`define B3C_B2SC_RST 16'h0000
`define B3C_KEY_VALUE 16'h9716

// ----------------------------------------------------------------
// voltage code
// ----------------------------------------------------------------
`define B3C_VCODE_MAX 7'h65
`define B3C_VMIN_MV 850
`define B3C_VSTEP_MV 25

// ----------------------------------------------------------------
// soft-start step times
// ----------------------------------------------------------------
`define B3C_CLK_MHZ 50
`define B3C_SS1_US 512
`define B3C_SS2_US 4096
`define B3C_SS3_US 32768
`define B3C_SS1_CYC (`B3C_SS1_US * `B3C_CLK_MHZ)
`define B3C_SS2_CYC (`B3C_SS2_US * `B3C_CLK_MHZ)
`define B3C_SS3_CYC (`B3C_SS3_US * `B3C_CLK_MHZ)
`define B3C_SS_STEPS 3

`endif

// [verilog/b3c_pkg.sv]
// Purpose: types for the buck3 register slice
// Assumes: nothing
// Notes: state structs used by b3c_top and b3c_sstart
package b3c_pkg;
  typedef enum logic [1:0] {
    B3C_SS_IDLE,
    B3C_SS_STEP,
    B3C_SS_DONE
  } b3c_ss_state_e;

  typedef struct packed {
    b3c_ss_state_e state;
    logic [1:0] step;
    logic [21:0] count;
    logic [1:0] limit_stage;
    logic done;
  } b3c_ss_s;

  typedef struct packed {
    logic [15:0] ctrl1;
    logic [15:0] ctrl2;
    logic [15:0] oncfg;
    logic [15:0] b2sc;
    logic unlocked;
    logic [31:0] readdata;
    logic waitrequest;
    logic resp_pending;
    logic [11:0] vout_mv;
    logic [6:0] vcode;
  } b3c_regs_s;
endpackage

// [verilog/b3c_sstart.sv]
// Purpose: soft-start sequencer stepping through three current-limited steps
// Assumes: step time code from the control register
// Notes: code 0 finishes at once
`include "b3c_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module b3c_sstart (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic start,
  input wire logic [1:0] step_code,
  // status
  output logic [1:0] limit_stage,
  output logic done
);
  b3c_pkg::b3c_ss_s s_reg;
  b3c_pkg::b3c_ss_s s_next;
  logic [21:0] step_len;

  always_comb begin
    case (step_code)
      2'h1: step_len = 22'(`B3C_SS1_CYC - 1);
      2'h2: step_len = 22'(`B3C_SS2_CYC - 1);
      default: step_len = 22'(`B3C_SS3_CYC - 1);
    endcase
  end

  always_comb begin
    s_next = s_reg;
    case (s_reg.state)
      b3c_pkg::B3C_SS_IDLE: begin
        if (start) begin
          s_next.done = 1'b0;
          s_next.step = 2'h0;
          s_next.count = 22'h0;
          s_next.limit_stage = 2'h1;
          if (step_code == 2'h0) begin
            s_next.state = b3c_pkg::B3C_SS_DONE;
            s_next.limit_stage = 2'h0;
          end else begin
            s_next.state = b3c_pkg::B3C_SS_STEP;
          end
        end
      end
      b3c_pkg::B3C_SS_STEP: begin
        if (s_reg.count >= step_len) begin
          s_next.count = 22'h0;
          if (s_reg.step == 2'(`B3C_SS_STEPS - 1)) begin
            s_next.state = b3c_pkg::B3C_SS_DONE;
            s_next.limit_stage = 2'h0;
          end else begin
            s_next.step = s_reg.step + 2'h1;
            s_next.limit_stage = s_reg.limit_stage + 2'h1;
          end
        end else begin
          s_next.count = s_reg.count + 22'h1;
        end
      end
      b3c_pkg::B3C_SS_DONE: begin
        s_next.done = 1'b1;
        if (start) begin
          s_next.done = 1'b0;
          s_next.step = 2'h0;
          s_next.count = 22'h0;
          s_next.limit_stage = 2'h1;
          if (step_code == 2'h0) begin
            s_next.limit_stage = 2'h0;
          end else begin
            s_next.state = b3c_pkg::B3C_SS_STEP;
          end
        end
      end
      default: s_next.state = b3c_pkg::B3C_SS_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign limit_stage = s_reg.limit_stage;
  assign done = s_reg.done;
endmodule
`default_nettype wire

// [dv/b3c_checker.sv]
// Purpose: port checks for b3c_top
// Assumes: one clock, synchronous active-low reset
// Notes: bound into every b3c_top
`timescale 1ns/1ns
`default_nettype none
module b3c_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // control
  input wire logic cfg_load,
  input wire logic ss_start,
  input wire logic [1:0] soft_start_step_time,
  input wire logic [1:0] hysteretic_current_limit,
  input wire logic [1:0] output_capacitor_range,
  input wire logic [6:0] on_state_voltage_code,
  input wire logic [11:0] on_voltage_mv,
  input wire logic [1:0] ss_limit_stage,
  input wire logic ss_done
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_taken; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence s_answer; !avs_waitrequest ##1 avs_waitrequest; endsequence
  property p_answer; s_taken |=> s_answer; endproperty
  property p_reset; $rose(rst_n) |-> soft_start_step_time == 2'h1 &&
    hysteretic_current_limit == 2'h1 && output_capacitor_range == 2'h0 &&
    on_state_voltage_code == 7'h00; endproperty
  property p_clamp; on_state_voltage_code <= 7'h65; endproperty
  property p_mv; on_voltage_mv == 12'h352 + 12'h019 * {5'h00, on_state_voltage_code}; endproperty
  property p_cap; $changed(output_capacitor_range) |->
    $past(cfg_load) || $past(cfg_load, 2) || $past(cfg_load, 3); endproperty
  property p_ss_fast; ss_start && soft_start_step_time == 2'h0 |-> ##[1:6] ss_done; endproperty
  property p_done_stage; ss_done |-> ss_limit_stage == 2'h0; endproperty
  property p_rdata; !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000; endproperty
  a_answer: assert property (p_answer) else $error("bus answer timing wrong");
  a_reset: assert property (p_reset) else $error("reset field values wrong");
  a_clamp: assert property (p_clamp) else $error("voltage code above 65h");
  a_mv: assert property (p_mv) else $error("voltage in mV wrong");
  a_cap: assert property (p_cap) else $error("capacitor range changed without load");
  a_ss_fast: assert property (p_ss_fast) else $error("immediate start not done");
  a_done_stage: assert property (p_done_stage) else $error("stage set while done");
  a_rdata: assert property (p_rdata) else $error("upper read data not zero");
endmodule
bind b3c_top b3c_checker i_chk (.clk, .rst_n, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .cfg_load, .ss_start, .soft_start_step_time, .hysteretic_current_limit,
  .output_capacitor_range, .on_state_voltage_code, .on_voltage_mv, .ss_limit_stage, .ss_done);
`default_nettype wire

// [dv/b3c_top_tb.sv]
// Purpose: self-checking bench for b3c_top
// Assumes: one wait state per bus access
// Notes: soft-start code 1 only checked for its first stage; codes 2 and 3 not run
`timescale 1ns/1ns
`default_nettype none
module b3c_top_tb;
  typedef struct packed {logic [17:0] a; logic [15:0] d; logic [15:0] e;} b3c_row_s;
  logic clk, rst_n, avs_read, avs_write, avs_waitrequest, cfg_load, ss_start, ovp, done;
  logic [17:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdq;
  logic [1:0] cfg_cap, sst, lim, cap, stg;
  logic [4:0] cfg_vhi;
  logic [3:0] be;
  logic [6:0] vcode;
  logic [11:0] mv;
  int miscompares = 0;
  int samples_checked = 0;
  int n;
  b3c_row_s rows [7] = '{'{18'h10184, 16'hFFFF, 16'hDF80}, '{18'h10184, 16'h0000, 16'h0000},
    '{18'h10188, 16'hFFFF, 16'hE37F}, '{18'h10188, 16'h007C, 16'h007C},
    '{18'h10180, 16'hFFFF, 16'h10B4}, '{18'h10300, 16'hFFFF, 16'h0000},
    '{18'h1017C, 16'hFFFF, 16'h187F}};
  b3c_top i_dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(be),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cfg_load(cfg_load),
    .cfg_capacitor(cfg_cap), .cfg_voltage_hi(cfg_vhi), .ss_start(ss_start),
    .soft_start_step_time(sst), .hysteretic_current_limit(lim), .output_capacitor_range(cap),
    .overvoltage_protect_enable(ovp), .on_state_voltage_code(vcode), .on_voltage_mv(mv),
    .ss_limit_stage(stg), .ss_done(done));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic final_report();
    $display("checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [17:0] ad, input logic [15:0] d);
    int k;
    k = 0;
    @(posedge clk);
    avs_address <= ad;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {16'h0000, d};
    do begin @(posedge clk); k++; end while (avs_waitrequest !== 1'b0 && k < 20);
    rdq = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (k >= 20) begin
      miscompares++;
      final_report();
    end
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic pulse_start();
    @(posedge clk);
    ss_start <= 1'b1;
    @(posedge clk);
    ss_start <= 1'b0;
  endtask
  initial begin
    {rst_n, avs_read, avs_write, cfg_load, ss_start, cfg_cap, cfg_vhi} = '0;
    avs_address = '0;
    avs_writedata = '0;
    be = 4'hF;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    bus(0, 18'h10180, 16'h0000);
    chk("ctrl1", rdq, 32'h0014);
    bus(0, 18'h10184, 16'h0000);
    chk("ctrl2", rdq, 32'h0300);
    bus(0, 18'h10188, 16'h0000);
    chk("oncfg", rdq, 32'h0000);
    chk("mv", 32'(mv), 32'h352);
    $display("reset test done");
    foreach (rows[i]) begin
      bus(1, rows[i].a, rows[i].d);
      bus(0, rows[i].a, 16'h0000);
      chk("row", rdq, {16'h0000, rows[i].e});
    end
    settle();
    chk("vcode", 32'(vcode), 32'h65);
    chk("mv", 32'(mv), 32'hD2F);
    bus(1, 18'h10184, 16'h0080);
    settle();
    chk("ovp", 32'(ovp), 32'h1);
    $display("table test done");
    be <= 4'h1;
    bus(1, 18'h10200, 16'h9716);
    be <= 4'hF;
    bus(0, 18'h10200, 16'h0000);
    chk("half key", 32'(rdq[0]), 32'h0);
    bus(1, 18'h10200, 16'h9716);
    bus(0, 18'h10200, 16'h0000);
    chk("key", 32'(rdq[0]), 32'h1);
    for (int c = 0; c < 4; c++) begin
      bus(1, 18'h10180, {12'h000, 2'(c), 2'h0});
      settle();
      chk("limit", 32'(lim), 32'(c));
    end
    bus(1, 18'h10200, 16'h0000);
    bus(1, 18'h10180, 16'h0004);
    bus(0, 18'h10180, 16'h0000);
    chk("locked", rdq, 32'h000C);
    $display("key test done");
    @(posedge clk);
    cfg_load <= 1'b1;
    cfg_cap <= 2'h3;
    cfg_vhi <= 5'h19;
    @(posedge clk);
    cfg_load <= 1'b0;
    settle();
    chk("cap", 32'(cap), 32'h3);
    chk("vcode", 32'(vcode), 32'h64);
    chk("mv", 32'(mv), 32'hD16);
    bus(0, 18'h10188, 16'h0000);
    chk("oncfg", rdq, 32'h0064);
    $display("load test done");
    pulse_start();
    n = 0;
    do begin @(negedge clk); n++; end while (done !== 1'b1 && n < 20);
    chk("done", 32'(done), 32'h1);
    chk("stage", 32'(stg), 32'h0);
    bus(1, 18'h10180, 16'h001C);
    pulse_start();
    n = 0;
    do begin @(negedge clk); n++; end while (stg === 2'h0 && n < 20);
    chk("stage", 32'(stg), 32'h1);
    chk("done", 32'(done), 32'h0);
    $display("soft-start test done");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("stage after reset", 32'(stg), 32'h0);
    chk("step", 32'(sst), 32'h1);
    chk("cap", 32'(cap), 32'h0);
    bus(0, 18'h10200, 16'h0000);
    chk("relock", 32'(rdq[0]), 32'h0);
    bus(0, 18'h10180, 16'h0000);
    chk("ctrl1 after reset", rdq, 32'h0014);
    $display("second reset test done");
    final_report();
  end
endmodule
`default_nettype wire
